// ===== rtl/speed_cmd_pkg.sv
package speed_cmd_pkg;
  // oscillator rate
  localparam longint CLK_HZ = 250000000;
  // pwm frequency floor in millihertz, period limit derived
  localparam longint PWM_MIN_MHZ = 7600;
  localparam longint PWM_MAX_PERIOD_CYC = (CLK_HZ * 1000) / PWM_MIN_MHZ;
  // accuracy limit of duty measurement
  localparam longint PWM_MAX_ACC_HZ = 1000;
  localparam longint PWM_MIN_ACC_PERIOD_CYC = CLK_HZ / PWM_MAX_ACC_HZ;
  // sleep and wake timing
  localparam longint SLEEP_HIGH_US = 524000;
  localparam longint SLEEP_HIGH_CYC = (CLK_HZ / 1000000) * SLEEP_HIGH_US;
  localparam longint WAKE_ANALOG_US = 8200;
  localparam longint WAKE_ANALOG_CYC = (CLK_HZ / 1000000) * WAKE_ANALOG_US;
  // duty thresholds in percent
  localparam int DUTY_START_PCT = 12;
  localparam int DUTY_STOP_PCT = 8;
  localparam int DUTY_FULL_PCT = 100;
  // analog thresholds in millivolts
  localparam int ANA_START_MV = 600;
  localparam int ANA_STOP_MV = 400;
  localparam int ANA_FULL_MV = 5000;
  // edges needed to resume pwm source after wake
  localparam logic [1:0] WAKE_EDGES = 2'h2;

  typedef enum logic [1:0] {SRC_NONE, SRC_PWM, SRC_ANALOG} source_type;

  // six pre-driver gate levels
  typedef struct packed {
    logic u_high;
    logic v_high;
    logic w_high;
    logic u_low;
    logic v_low;
    logic w_low;
  } gate_set_type;
endpackage : speed_cmd_pkg

// ===== rtl/motor_speed_command_select.sv
`timescale 1ns/1ps
// Overview of operation
// [RULE1] gate enable high passes the gate outputs, low forces all six low.
// [RULE2] the pwm pin is the speed source above 7.6 Hz, otherwise the analog pin.
// [RULE3] pwm from 7.6 Hz to 1 kHz is taken, faster input is taken with loose accuracy.
// [RULE4] stopped under pwm, drive starts when duty reaches 12 percent or more.
// [RULE5] running under pwm, drive stops when duty falls to 8 percent or less.
// [RULE6] a duty of 100 percent takes the speed from the analog input.
// [RULE7] with no edges on the pwm pin the speed follows the analog input.
// [RULE8] under analog, drive starts at 0.6 V or more and stops at 0.4 V or less.
// [RULE9] the controller holds the pwm pin low for as long as analog control is used.
// [RULE10] sleep is entered when the pwm pin stays high long enough, never while low.
// [RULE11] sleep stops the main regulator and holds every gate output low.
// [RULE12] pwm high for 524 ms or more is the sleep condition, and logic resets on entry.
// [RULE13] after wake analog data is taken after 8.2 ms, pwm only after two rising edges.
// [RULE14] duty is high-time cycles over period cycles between rising edges.
module motor_speed_command_select #(
  parameter int CNT_W = 32,
  parameter int MV_W = 13,
  parameter longint SLEEP_CYC = speed_cmd_pkg::SLEEP_HIGH_CYC,
  parameter longint WAKE_CYC = speed_cmd_pkg::WAKE_ANALOG_CYC,
  parameter longint ACC_PERIOD_CYC = speed_cmd_pkg::PWM_MIN_ACC_PERIOD_CYC,
  parameter longint PERIOD_MAX_CYC = speed_cmd_pkg::PWM_MAX_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic gate_output_enable_pin,
  input wire logic pwm_speed_command_pin,
  input wire logic [MV_W-1:0] analog_speed_command_pin,
  input wire speed_cmd_pkg::gate_set_type gate_request,
  output speed_cmd_pkg::gate_set_type gate_drive,
  output logic regulator_pass_drive,
  output logic sleep_active,
  output logic motor_run,
  output logic [6:0] speed_command_pct,
  output speed_cmd_pkg::source_type source_sel,
  output logic duty_accurate
);
  logic pin_prev_reg;
  logic [CNT_W-1:0] hi_cnt_reg, hi_cnt_next, per_cnt_reg, per_cnt_next;
  logic [CNT_W-1:0] high_run_reg, high_run_next, wake_cnt_reg, wake_cnt_next;
  logic [6:0] duty_reg, duty_next;
  logic [1:0] edges_reg, edges_next;
  logic pwm_ok_reg, pwm_ok_next, analog_ok_reg, analog_ok_next;
  logic run_next, sleep_next, acc_next;
  logic [6:0] speed_next;
  speed_cmd_pkg::source_type src_next;
  speed_cmd_pkg::gate_set_type gate_next;
  logic rise, full_duty;
  logic [6:0] ana_pct;

  // integer ratio in percent, capped at 100
  function automatic logic [6:0] pct(input logic [CNT_W-1:0] num, input logic [CNT_W-1:0] den);
    logic [CNT_W+6:0] prod;
    logic [CNT_W+6:0] q;
    prod = {7'h00, num} * (CNT_W+7)'(100);
    q = (den == '0) ? (CNT_W+7)'(0) : prod / {7'h00, den};
    pct = (q > (CNT_W+7)'(100)) ? 7'h64 : q[6:0];
  endfunction : pct

  assign rise = pwm_speed_command_pin & ~pin_prev_reg;
  assign ana_pct = pct(CNT_W'(analog_speed_command_pin), CNT_W'(speed_cmd_pkg::ANA_FULL_MV));
  assign full_duty = duty_reg == 7'(speed_cmd_pkg::DUTY_FULL_PCT);

  // duty measurement, edge qualification and sleep timing
  always_comb
  begin
    hi_cnt_next = hi_cnt_reg + (pwm_speed_command_pin ? CNT_W'(1) : CNT_W'(0)); // RULE14
    per_cnt_next = per_cnt_reg + CNT_W'(1);
    duty_next = duty_reg;
    edges_next = edges_reg;
    pwm_ok_next = pwm_ok_reg;
    acc_next = duty_accurate;
    if (rise)
    begin
      duty_next = pct(hi_cnt_reg, per_cnt_reg); // RULE14
      acc_next = per_cnt_reg >= CNT_W'(ACC_PERIOD_CYC); // RULE3
      hi_cnt_next = CNT_W'(1);
      per_cnt_next = CNT_W'(1);
      if (edges_reg != speed_cmd_pkg::WAKE_EDGES)
        edges_next = edges_reg + 2'h1;
      pwm_ok_next = (edges_reg == speed_cmd_pkg::WAKE_EDGES) || (edges_reg == 2'h1); // RULE13
    end
    else if (per_cnt_reg >= CNT_W'(PERIOD_MAX_CYC))
    begin
      pwm_ok_next = 1'b0; // RULE2 RULE7
      edges_next = 2'h0;
      per_cnt_next = per_cnt_reg;
      duty_next = pwm_speed_command_pin ? 7'h64 : 7'h00;
    end
    high_run_next = pwm_speed_command_pin ? high_run_reg + CNT_W'(1) : CNT_W'(0); // RULE10
    wake_cnt_next = wake_cnt_reg;
    analog_ok_next = analog_ok_reg;
    if (wake_cnt_reg >= CNT_W'(WAKE_CYC - 1))
      analog_ok_next = 1'b1; // RULE13
    else
      wake_cnt_next = wake_cnt_reg + CNT_W'(1);
  end

  // source choice, start and stop hysteresis, gate masking
  always_comb
  begin
    // pin must still be high now, so a late drop never enters sleep
    sleep_next = pwm_speed_command_pin && high_run_reg >= CNT_W'(SLEEP_CYC - 1); // RULE12
    src_next = speed_cmd_pkg::SRC_NONE;
    speed_next = 7'h00;
    run_next = motor_run;
    if (pwm_ok_reg && !full_duty)
    begin
      src_next = speed_cmd_pkg::SRC_PWM; // RULE2
      speed_next = duty_reg;
      if (!motor_run && duty_reg >= 7'(speed_cmd_pkg::DUTY_START_PCT))
        run_next = 1'b1; // RULE4
      else if (motor_run && duty_reg <= 7'(speed_cmd_pkg::DUTY_STOP_PCT))
        run_next = 1'b0; // RULE5
    end
    else if (analog_ok_reg)
    begin
      src_next = speed_cmd_pkg::SRC_ANALOG; // RULE6 RULE7
      speed_next = ana_pct;
      if (!motor_run && analog_speed_command_pin >= MV_W'(speed_cmd_pkg::ANA_START_MV))
        run_next = 1'b1; // RULE8
      else if (motor_run && analog_speed_command_pin <= MV_W'(speed_cmd_pkg::ANA_STOP_MV))
        run_next = 1'b0; // RULE8
    end
    else
      run_next = 1'b0;
    gate_next = gate_output_enable_pin && run_next && !sleep_next ? gate_request : '0; // RULE1
  end

  // registers; while asleep all logic except sleep_active and regulator_pass_drive is cleared like a reset
  always_ff @(posedge clk)
  begin
    if (!rst_n || sleep_active) // RULE12
    begin
      pin_prev_reg <= 1'b1;
      hi_cnt_reg <= '0;
      per_cnt_reg <= '0;
      high_run_reg <= '0;
      wake_cnt_reg <= '0;
      duty_reg <= 7'h00;
      edges_reg <= 2'h0;
      pwm_ok_reg <= 1'b0;
      analog_ok_reg <= 1'b0;
      motor_run <= 1'b0;
      speed_command_pct <= 7'h00;
      source_sel <= speed_cmd_pkg::SRC_NONE;
      duty_accurate <= 1'b0;
      gate_drive <= '0;
      regulator_pass_drive <= !rst_n || !pwm_speed_command_pin; // RULE11 off while asleep
      sleep_active <= !rst_n ? 1'b0 : pwm_speed_command_pin; // RULE10 falling edge wakes
    end
    else
    begin
      pin_prev_reg <= pwm_speed_command_pin;
      hi_cnt_reg <= hi_cnt_next;
      per_cnt_reg <= per_cnt_next;
      high_run_reg <= high_run_next;
      wake_cnt_reg <= wake_cnt_next;
      duty_reg <= duty_next;
      edges_reg <= edges_next;
      pwm_ok_reg <= pwm_ok_next;
      analog_ok_reg <= analog_ok_next;
      motor_run <= run_next && !sleep_next;
      speed_command_pct <= speed_next;
      source_sel <= src_next;
      duty_accurate <= acc_next;
      gate_drive <= gate_next; // RULE11
      regulator_pass_drive <= !sleep_next; // RULE11
      sleep_active <= sleep_next;
    end
  end

  property p_gate_off;
    @(posedge clk) disable iff (!rst_n)
    !gate_output_enable_pin |=> gate_drive == '0;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gates not low with enable low"); // RULE1

  property p_sleep_gates;
    @(posedge clk) disable iff (!rst_n)
    sleep_active |-> gate_drive == '0 && !regulator_pass_drive;
  endproperty
  a_sleep_gates: assert property (p_sleep_gates) else $error("sleep left gates on"); // RULE11

  property p_no_sleep_low;
    @(posedge clk) disable iff (!rst_n)
    !$past(pwm_speed_command_pin) |-> !$rose(sleep_active);
  endproperty
  a_no_sleep_low: assert property (p_no_sleep_low) else $error("sleep while pin low"); // RULE10

  property p_start_pwm;
    @(posedge clk) disable iff (!rst_n || sleep_active)
    source_sel == speed_cmd_pkg::SRC_PWM && $rose(motor_run) |->
      speed_command_pct >= 7'(speed_cmd_pkg::DUTY_START_PCT);
  endproperty
  a_start_pwm: assert property (p_start_pwm) else $error("pwm start below threshold"); // RULE4

  property p_stop_pwm;
    @(posedge clk) disable iff (!rst_n || sleep_active)
    $past(source_sel) == speed_cmd_pkg::SRC_PWM && source_sel == speed_cmd_pkg::SRC_PWM
      && $fell(motor_run) |-> speed_command_pct <= 7'(speed_cmd_pkg::DUTY_STOP_PCT);
  endproperty
  a_stop_pwm: assert property (p_stop_pwm) else $error("pwm stop above threshold"); // RULE5

  property p_full_analog;
    @(posedge clk) disable iff (!rst_n || sleep_active)
    full_duty |=> source_sel != speed_cmd_pkg::SRC_PWM;
  endproperty
  a_full_analog: assert property (p_full_analog) else $error("full duty kept pwm source"); // RULE6

  property p_analog_start;
    @(posedge clk) disable iff (!rst_n || sleep_active)
    source_sel == speed_cmd_pkg::SRC_ANALOG && $rose(motor_run) |->
      $past(analog_speed_command_pin) >= MV_W'(speed_cmd_pkg::ANA_START_MV);
  endproperty
  a_analog_start: assert property (p_analog_start) else $error("analog start low"); // RULE8

  property p_pwm_edges;
    @(posedge clk) disable iff (!rst_n || sleep_active)
    source_sel == speed_cmd_pkg::SRC_PWM |-> $past(edges_reg) != 2'h0;
  endproperty
  a_pwm_edges: assert property (p_pwm_edges) else $error("pwm source without edges"); // RULE13
endmodule : motor_speed_command_select

// ===== bench/vehicle_ctrl_model.sv
`timescale 1ns/1ps
// vehicle controller: pwm command, steady low for analog use, steady high to request sleep
module vehicle_ctrl_model (
  input wire logic clk,
  input wire logic [1:0] mode,
  input wire logic [7:0] high_cyc,
  input wire logic [7:0] period_cyc,
  output logic pwm_pin
);
  logic [7:0] phase_reg = 8'h00;
  initial pwm_pin = 1'b0;
  // free phase counter, pin changed just after the edge
  always @(posedge clk)
  begin
    phase_reg <= #1 (phase_reg + 8'h01 >= period_cyc) ? 8'h00 : phase_reg + 8'h01;
    pwm_pin <= #1 (mode == 2'h1) ? (phase_reg < high_cyc) : (mode == 2'h2);
  end
endmodule : vehicle_ctrl_model

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic sleep;
    logic run;
    speed_cmd_pkg::source_type src;
    logic [6:0] pct;
    speed_cmd_pkg::gate_set_type gates;
    logic acc;
  } expect_type;
  localparam speed_cmd_pkg::source_type src_none = speed_cmd_pkg::SRC_NONE;
  localparam speed_cmd_pkg::source_type src_pwm = speed_cmd_pkg::SRC_PWM;
  localparam speed_cmd_pkg::source_type src_an = speed_cmd_pkg::SRC_ANALOG;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic enable = 1'b1;
  logic [12:0] analog_mv = 13'h0BB8;
  speed_cmd_pkg::gate_set_type gate_request = 6'h21;
  logic [1:0] mode = 2'h0;
  logic [7:0] high_cyc = 8'h00;
  logic [7:0] period_cyc = 8'h32;
  logic pwm_pin, regulator_pass_drive, sleep_active, motor_run, check_req = 1'b0;
  speed_cmd_pkg::gate_set_type gate_drive;
  logic [6:0] speed_command_pct;
  logic duty_accurate, acc_exp = 1'b0;
  speed_cmd_pkg::source_type source_sel;
  expect_type expect_q[$];
  expect_type got_e;
  int mismatches = 0;
  int checks_done = 0;
  int tab[4] = '{10, 8, 10, 12};
  logic run_tab[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  always #2 clk = ~clk;
  vehicle_ctrl_model vehicle_ctrl_model_i (.clk(clk), .mode(mode), .high_cyc(high_cyc),
    .period_cyc(period_cyc), .pwm_pin(pwm_pin));
  motor_speed_command_select #(.SLEEP_CYC(200), .WAKE_CYC(20), .PERIOD_MAX_CYC(100),
    .ACC_PERIOD_CYC(50))
    motor_speed_command_select_i (.clk(clk), .rst_n(rst_n), .gate_output_enable_pin(enable),
    .pwm_speed_command_pin(pwm_pin), .analog_speed_command_pin(analog_mv),
    .gate_request(gate_request), .gate_drive(gate_drive),
    .regulator_pass_drive(regulator_pass_drive), .sleep_active(sleep_active),
    .motor_run(motor_run), .speed_command_pct(speed_command_pct),
    .source_sel(source_sel), .duty_accurate(duty_accurate));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // note the expected outputs and ask the watcher to compare at the next edge
  task automatic expect_now(input logic slp, input logic run,
    input speed_cmd_pkg::source_type src, input int pct);
    expect_q.push_back({slp, run, src, 7'(pct),
      ((run && enable) ? gate_request : 6'h00), acc_exp});
    check_req = 1'b1;
    cyc(1);
    check_req = 1'b0;
  endtask : expect_now
  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // compare settled outputs with the oldest note
  always @(posedge clk)
  begin
    if (check_req)
    begin
      got_e = expect_q.pop_front();
      checks_done++;
      if ({sleep_active, motor_run, source_sel, speed_command_pct, gate_drive, duty_accurate}
          !== got_e || regulator_pass_drive !== !got_e.sleep)
      begin
        mismatches++;
        $display("[FAIL] %0t outputs %h, expected %h", $time,
          {sleep_active, motor_run, source_sel, speed_command_pct, gate_drive, duty_accurate},
          got_e);
      end
    end
  end
  // main sequence
  initial
  begin
    void'($urandom(32'h8A7D));
    cyc(3);
    rst_n = 1'b1;
    cyc(4);
    expect_now(0, 0, src_none, 0);
    cyc(25);
    expect_now(0, 1, src_an, 60);
    for (int s = 0; s < 2; s++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        analog_mv = 13'(tab[i] * 50);
        high_cyc = 8'(tab[i] / 2);
        cyc(s == 0 ? 4 : 150);
        expect_now(0, run_tab[i], s == 0 ? src_an : src_pwm, tab[i]);
      end
      if (s == 0)
      begin
        enable = 1'b0;
        gate_request = 6'($urandom);
        cyc(2);
        expect_now(0, 1, src_an, 12);
        enable = 1'b1;
        cyc(2);
        expect_now(0, 1, src_an, 12);
        analog_mv = 13'h0000;
        cyc(4);
        expect_now(0, 0, src_an, 0);
        high_cyc = 8'(6 + $urandom % 40);
        mode = 2'h1;
        acc_exp = 1'b1;
        cyc(150);
        expect_now(0, 1, src_pwm, 2 * high_cyc);
      end
    end
    analog_mv = 13'h0BB8;
    mode = 2'h2;
    acc_exp = 1'b0;
    cyc(150);
    expect_now(0, 1, src_an, 60);
    cyc(60);
    expect_now(1, 0, src_none, 0);
    mode = 2'h0;
    cyc(3);
    expect_now(0, 0, src_none, 0);
    cyc(25);
    expect_now(0, 1, src_an, 60);
    high_cyc = 8'h14;
    mode = 2'h1;
    @(posedge pwm_pin);
    cyc(5);
    expect_now(0, 1, src_an, 60);
    acc_exp = 1'b1;
    cyc(100);
    expect_now(0, 1, src_pwm, 40);
    print_verdict();
  end
  // watchdog against a hang
  initial
  begin
    #40000;
    mismatches++;
    print_verdict();
  end
endmodule : tb
